// ===== hdl/dfc_pkg.sv
// Package for the data fault cause register block
package dfc_pkg;

  localparam int DFC_W = 32;

  // Field positions
  localparam int FNV_BIT = 16;
  localparam int CM_BIT = 13;
  localparam int EXT_BIT = 12;
  localparam int WNR_BIT = 11;
  localparam int LDF_BIT = 9;
  localparam int STAT_LSB = 0;
  localparam int STAT_W = 6;

  // Writable bits mask, bit 9 reads one
  localparam logic [31:0] RW_MASK = 32'h0001_383f;
  localparam logic [31:0] RES1_MASK = 32'h0000_0200;

  // Coprocessor encoding of the register
  localparam logic [3:0] ENC_COPROC = 4'hf;
  localparam logic [2:0] ENC_OPC1 = 3'h0;
  localparam logic [3:0] ENC_CRN = 4'h5;
  localparam logic [3:0] ENC_CRM = 4'h0;
  localparam logic [2:0] ENC_OPC2 = 3'h0;
  // Coproc encoding space of cache and translation system instructions
  localparam logic [2:0] SYS_SPACE = 3'h7;

  // Exception levels
  localparam logic [1:0] EL0 = 2'h0;
  localparam logic [1:0] EL1 = 2'h1;

  // Fault class codes
  typedef enum logic [5:0] {
    FC_TRANSLATION = 6'h04,
    FC_PERMISSION = 6'h0c,
    FC_SYNC_EXT = 6'h10,
    FC_SYSTEM_ERROR_INTERRUPT = 6'h11,
    FC_SYNC_PARITY = 6'h18,
    FC_SYSTEM_ERROR_INTERRUPT_PARITY = 6'h19,
    FC_ALIGNMENT = 6'h21,
    FC_DEBUG = 6'h22,
    FC_LOCKDOWN = 6'h34,
    FC_EXCL_UNSUP = 6'h35
  } dfc_class_t;

  // Fault report from the load/store pipeline
  typedef struct packed {
    logic valid;
    dfc_class_t fclass;
    logic write;
    logic cache_maint;
    logic sys_space;
    logic ext_type;
    logic far_invalid;
  } dfc_fault_t;

  // Coprocessor transfer request
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] el;
    logic [3:0] coproc;
    logic [2:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
    logic [31:0] wdata;
  } dfc_xfer_t;

  // Transfer outcome
  typedef struct packed {
    logic done;
    logic hyp_trap;
    logic undef;
    logic [31:0] rdata;
  } dfc_resp_t;

endpackage : dfc_pkg

// ===== hdl/dfc_status.sv
// Data fault cause register with fault capture and access traps
`timescale 1ns/100ps

module dfc_status
  import dfc_pkg::*;
#(
  parameter bit HYP_PRESENT = 1'b1,
  parameter bit EXT_CLASSIFY = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  input dfc_fault_t fault_i,
  input dfc_xfer_t xfer_i,
  input wire logic hyp_trap_memctl_writes,
  input wire logic hyp_trap_memctl_reads,
  input wire logic hyp_trap_primary_reg5,
  output dfc_resp_t resp_o,
  output logic [31:0] data_fault_cause_o
);

  logic [31:0] cause_q;
  logic [31:0] cause_d;
  dfc_resp_t resp_q;
  dfc_resp_t resp_d;

  // Without a classification scheme bit 12 stays zero, even on writes
  localparam logic [31:0] SW_MASK =
    RW_MASK & ~(32'(!EXT_CLASSIFY) << EXT_BIT);

  function automatic logic is_known_class(input logic [5:0] c);
    case (c)
      FC_TRANSLATION, FC_PERMISSION, FC_SYNC_EXT, FC_SYSTEM_ERROR_INTERRUPT,
      FC_SYNC_PARITY, FC_SYSTEM_ERROR_INTERRUPT_PARITY, FC_ALIGNMENT, FC_DEBUG,
      FC_LOCKDOWN, FC_EXCL_UNSUP: is_known_class = 1'b1;
      default: is_known_class = 1'b0;
    endcase
  endfunction : is_known_class

  function automatic logic is_sync(input logic [5:0] c);
    is_sync = (c != FC_SYSTEM_ERROR_INTERRUPT) && (c != FC_SYSTEM_ERROR_INTERRUPT_PARITY);
  endfunction : is_sync

  function automatic logic is_external(input logic [5:0] c);
    is_external = (c == FC_SYNC_EXT) || (c == FC_SYSTEM_ERROR_INTERRUPT) ||
                  (c == FC_SYNC_PARITY) || (c == FC_SYSTEM_ERROR_INTERRUPT_PARITY);
  endfunction : is_external

  // Register selection
  wire sel_hit = xfer_i.valid && (xfer_i.coproc == ENC_COPROC) &&
    (xfer_i.opc1 == ENC_OPC1) && (xfer_i.crn == ENC_CRN) &&
    (xfer_i.crm == ENC_CRM) && (xfer_i.opc2 == ENC_OPC2);
  wire from_el0 = xfer_i.el == EL0;
  wire from_el1 = xfer_i.el == EL1;
  wire undef_acc = sel_hit && from_el0;
  wire trap_wr = xfer_i.write && hyp_trap_memctl_writes;
  wire trap_rd = !xfer_i.write && hyp_trap_memctl_reads;
  wire trap_acc = sel_hit && from_el1 && HYP_PRESENT &&
    (trap_wr || trap_rd || hyp_trap_primary_reg5);
  wire do_write = sel_hit && xfer_i.write && !undef_acc && !trap_acc;
  wire do_read = sel_hit && !xfer_i.write && !undef_acc && !trap_acc;

  // Fault record build; unknown codes from a fault report never land in the register
  wire [5:0] fc = fault_i.fclass;
  wire fault_take = fault_i.valid && is_known_class(fc);
  wire sync_ext = (fc == FC_SYNC_EXT) || (fc == FC_SYNC_PARITY);
  wire f_fnv = sync_ext && fault_i.far_invalid;
  // Asynchronous value is unspecified; zero is the cheapest choice
  wire f_cm = is_sync(fc) && fault_i.cache_maint;
  wire f_ext = EXT_CLASSIFY && is_external(fc) && fault_i.ext_type;
  // Any system instruction fault in that space reports a write
  wire f_wnr = fault_i.write || fault_i.sys_space;
  wire [31:0] fault_word = RES1_MASK |
    (32'(f_fnv) << FNV_BIT) | (32'(f_cm) << CM_BIT) |
    (32'(f_ext) << EXT_BIT) | (32'(f_wnr) << WNR_BIT) |
    (32'(fc) << STAT_LSB);
  wire [31:0] sw_word = (xfer_i.wdata & SW_MASK) | RES1_MASK;

  // Hardware capture outranks a software write in the same cycle
  assign cause_d = fault_take ? fault_word :
                   do_write ? sw_word : cause_q;

  always_comb begin
    resp_d = '0;
    resp_d.done = sel_hit;
    resp_d.hyp_trap = trap_acc;
    resp_d.undef = undef_acc;
    resp_d.rdata = do_read ? cause_q : 32'h0000_0000;
  end

  // Reset value is unspecified; a clean constant is used
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cause_q <= RES1_MASK;
      resp_q <= '0;
    end else begin
      cause_q <= cause_d;
      resp_q <= resp_d;
    end
  end

  assign resp_o = resp_q;
  assign data_fault_cause_o = cause_q;

  // Fault capture checks
  a_fault_capture: assert property (
    @(posedge clk) disable iff (!reset_n)
    fault_take |=> cause_q[5:0] == $past(fc))
    else $error("fault class not captured");
  a_fnv_only_sync: assert property (
    @(posedge clk) disable iff (!reset_n)
    fault_take && !sync_ext |=> !cause_q[FNV_BIT])
    else $error("invalid-address flag on wrong class");
  a_fnv_capture: assert property (
    @(posedge clk) disable iff (!reset_n)
    fault_take && sync_ext
    |=> cause_q[FNV_BIT] == $past(fault_i.far_invalid))
    else $error("invalid-address flag lost");
  a_cm_async_zero: assert property (
    @(posedge clk) disable iff (!reset_n)
    fault_take && !is_sync(fc) |=> !cause_q[CM_BIT])
    else $error("cache flag on asynchronous fault");
  a_cm_sync: assert property (
    @(posedge clk) disable iff (!reset_n)
    fault_take && is_sync(fc)
    |=> cause_q[CM_BIT] == $past(fault_i.cache_maint))
    else $error("cache flag lost on synchronous fault");
  a_ext_zero: assert property (
    @(posedge clk) disable iff (!reset_n)
    fault_take && !is_external(fc) |=> !cause_q[EXT_BIT])
    else $error("external type bit on non-external abort");
  a_ext_unclassified: assert property (
    @(posedge clk) disable iff (!reset_n)
    EXT_CLASSIFY || !cause_q[EXT_BIT])
    else $error("external type bit set without classification");
  a_wnr_dir: assert property (
    @(posedge clk) disable iff (!reset_n)
    fault_take && fault_i.write |=> cause_q[WNR_BIT])
    else $error("write direction lost");
  a_wnr_read: assert property (
    @(posedge clk) disable iff (!reset_n)
    fault_take && !fault_i.write && !fault_i.sys_space
    |=> !cause_q[WNR_BIT])
    else $error("read fault marked write");
  a_wnr_sys: assert property (
    @(posedge clk) disable iff (!reset_n)
    fault_take && fault_i.sys_space |=> cause_q[WNR_BIT])
    else $error("system instruction fault not marked write");
  a_class_legal: assert property (
    @(posedge clk) disable iff (!reset_n)
    $changed(cause_q) && $past(fault_take)
    |-> is_known_class(cause_q[5:0]))
    else $error("reserved fault class produced");
  a_class_ignored: assert property (
    @(posedge clk) disable iff (!reset_n)
    fault_i.valid && !is_known_class(fc) && !do_write
    |=> $stable(cause_q))
    else $error("reserved fault class recorded");

  // Software access checks
  a_read_data: assert property (
    @(posedge clk) disable iff (!reset_n)
    do_read |=> resp_o.rdata == $past(cause_q))
    else $error("read data mismatch");
  a_sel_done: assert property (
    @(posedge clk) disable iff (!reset_n)
    sel_hit |=> resp_o.done)
    else $error("selected transfer not answered");
  a_unsel_quiet: assert property (
    @(posedge clk) disable iff (!reset_n)
    !sel_hit |=> !resp_o.done && !resp_o.hyp_trap && !resp_o.undef)
    else $error("answer without a selected transfer");
  a_write_lands: assert property (
    @(posedge clk) disable iff (!reset_n)
    do_write && !fault_take
    |=> cause_q == (($past(xfer_i.wdata) & SW_MASK) | RES1_MASK))
    else $error("register write not stored");
  a_write_rdata: assert property (
    @(posedge clk) disable iff (!reset_n)
    sel_hit && xfer_i.write |=> resp_o.rdata == 32'h0000_0000)
    else $error("write returned data");

  // Trap, refusal and reserved bit checks
  a_trap_wr: assert property (
    @(posedge clk) disable iff (!reset_n)
    HYP_PRESENT && sel_hit && from_el1 && xfer_i.write &&
    hyp_trap_memctl_writes && !fault_take
    |=> resp_o.hyp_trap && $stable(cause_q))
    else $error("trapped write not trapped");
  a_trap_rd: assert property (
    @(posedge clk) disable iff (!reset_n)
    HYP_PRESENT && sel_hit && from_el1 && !xfer_i.write &&
    hyp_trap_memctl_reads
    |=> resp_o.hyp_trap && resp_o.rdata == 32'h0000_0000)
    else $error("trapped read returned data");
  a_trap_t5: assert property (
    @(posedge clk) disable iff (!reset_n)
    HYP_PRESENT && sel_hit && from_el1 && hyp_trap_primary_reg5
    |=> resp_o.hyp_trap)
    else $error("register 5 trap missed");
  a_trap_t5_keep: assert property (
    @(posedge clk) disable iff (!reset_n)
    HYP_PRESENT && sel_hit && from_el1 && hyp_trap_primary_reg5 &&
    !fault_take |=> $stable(cause_q))
    else $error("register 5 trap changed the register");
  a_reserved: assert property (
    @(posedge clk) disable iff (!reset_n)
    (cause_q & ~RW_MASK) == RES1_MASK)
    else $error("reserved bits wrong");
  a_res1_bit: assert property (
    @(posedge clk) disable iff (!reset_n)
    cause_q[LDF_BIT])
    else $error("bit 9 not one");
  a_el0_undef: assert property (
    @(posedge clk) disable iff (!reset_n)
    sel_hit && from_el0 && !fault_take
    |=> resp_o.undef && !resp_o.hyp_trap && $stable(cause_q))
    else $error("EL0 access not refused");
  a_undef_only: assert property (
    @(posedge clk) disable iff (!reset_n)
    resp_o.undef |-> !resp_o.hyp_trap)
    else $error("refused access also trapped");

endmodule : dfc_status

// ===== verif/dfc_lsu_model.sv
// Load/store pipeline fault reporter model
`timescale 1ns/100ps
module dfc_lsu_model
  import dfc_pkg::*;
(
  input wire logic clk,
  output dfc_fault_t fault
);
  initial fault = '0;
  // One-cycle report; idle fields scrambled so stale values never match
  task automatic fire(input dfc_class_t c, input logic [4:0] f);
    dfc_fault_t r;
    @(posedge clk);
    #1;
    fault = dfc_fault_t'({1'b1, c, f});
    @(posedge clk);
    #1;
    r = dfc_fault_t'(~fault);
    r.valid = 1'b0;
    fault = r;
  endtask : fire
endmodule : dfc_lsu_model

// ===== verif/tb_dfc_status.sv
// Self-checking bench for the data fault cause register
`timescale 1ns/100ps
module tb_dfc_status
  import dfc_pkg::*;
;
  logic clk, reset_n, t_wr, t_rd, t_p5, sy, as;
  logic [15:0] lfsr;
  logic [4:0] f;
  logic [31:0] cause, reg_m;
  dfc_fault_t fault;
  dfc_xfer_t xfer;
  dfc_resp_t resp, e;
  dfc_resp_t q[$];
  dfc_class_t c;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  dfc_class_t cls[10] = '{FC_TRANSLATION, FC_PERMISSION, FC_SYNC_EXT,
    FC_SYSTEM_ERROR_INTERRUPT, FC_SYNC_PARITY, FC_SYSTEM_ERROR_INTERRUPT_PARITY, FC_ALIGNMENT, FC_DEBUG,
    FC_LOCKDOWN, FC_EXCL_UNSUP};

  dfc_status u_dut (.clk(clk), .reset_n(reset_n), .fault_i(fault),
    .xfer_i(xfer), .hyp_trap_memctl_writes(t_wr),
    .hyp_trap_memctl_reads(t_rd), .hyp_trap_primary_reg5(t_p5),
    .resp_o(resp), .data_fault_cause_o(cause));
  dfc_lsu_model u_lsu (.clk(clk), .fault(fault));

  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    cmp_count++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic summarize();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // One cycle per call; the next call or idle() retires the strobe
  task automatic xfr(input logic w, input logic [1:0] el,
      input logic [3:0] crn, input logic [31:0] d, input logic tr,
      input logic ud);
    @(posedge clk);
    #1;
    xfer = '{1'b1, w, el, ENC_COPROC, ENC_OPC1, crn, ENC_CRM, ENC_OPC2, d};
    if (crn == ENC_CRN) begin
      q.push_back(dfc_resp_t'{1'b1, tr, ud, (w | tr | ud) ? 32'h0 : reg_m});
      if (w && !tr && !ud) begin
        reg_m = (d & RW_MASK & ~(32'h1 << EXT_BIT)) | RES1_MASK;
      end
    end
  endtask : xfr

  task automatic idle();
    @(posedge clk);
    #1;
    xfer.valid = 1'b0;
  endtask : idle

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    forever @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
        bad_count++;
        summarize();
      end
    end
  end

  // Monitor: any response pops the oldest expectation
  always @(posedge clk) begin
    #3;
    if (resp.done === 1'b1 || resp.hyp_trap === 1'b1 ||
        resp.undef === 1'b1) begin
      e = q.size() > 0 ? q.pop_front() : 'x;
      check({resp.hyp_trap, resp.undef, resp.rdata},
        {e.hyp_trap, e.undef, e.rdata});
      if (!e.hyp_trap && !e.undef) check({33'h0, resp.done}, 34'h1);
    end
  end

  initial begin
    reset_n = 1'b0;
    xfer = '0;
    {t_wr, t_rd, t_p5} = 3'h0;
    lfsr = 16'h31c8;
    reg_m = RES1_MASK;
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b1;
    xfr(0, EL1, ENC_CRN, 0, 0, 0);
    xfr(1, EL1, ENC_CRN, 32'hffffffff, 0, 0);
    xfr(0, EL1, ENC_CRN, 0, 0, 0);
    xfr(1, EL1, 4'h6, 32'h0, 0, 0);
    xfr(0, EL1, ENC_CRN, 0, 0, 0);
    for (int k = 0; k < 3; k++) begin
      {t_wr, t_rd, t_p5} = 3'b100 >> k;
      xfr(1, EL1, ENC_CRN, 32'h1, k != 1, 0);
      xfr(0, EL1, ENC_CRN, 0, k != 0, 0);
      xfr(1, EL0, ENC_CRN, 32'h3f, 0, 1);
      xfr(1, 2'h2, ENC_CRN, 32'h800 << k, 0, 0);
      xfr(0, 2'h2, ENC_CRN, 0, 0, 0);
    end
    idle();
    {t_wr, t_rd, t_p5} = 3'h0;
    for (int i = 0; i < 30; i++) begin
      c = cls[i % 10];
      f = lfsr[4:0];
      lfsr = lfsr_next(lfsr);
      sy = (c == FC_SYNC_EXT || c == FC_SYNC_PARITY);
      as = (c == FC_SYSTEM_ERROR_INTERRUPT || c == FC_SYSTEM_ERROR_INTERRUPT_PARITY);
      reg_m = {15'h0, sy & f[0], 2'h0, f[3] & !as, 1'b0, f[4] | f[2],
        1'b0, 1'b1, 3'h0, c};
      u_lsu.fire(c, f);
      check({2'h0, cause}, {2'h0, reg_m});
      if (i % 5 == 4) begin
        xfr(0, EL1, ENC_CRN, 0, 0, 0);
        idle();
      end
    end
    u_lsu.fire(dfc_class_t'(6'h3f), 5'h1f);
    check({2'h0, cause}, {2'h0, reg_m});
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b1;
    reg_m = RES1_MASK;
    check({2'h0, cause}, {2'h0, RES1_MASK});
    xfr(0, EL1, ENC_CRN, 0, 0, 0);
    idle();
    repeat (3) @(posedge clk);
    check(34'(q.size()), 34'h0);
    summarize();
  end
endmodule : tb_dfc_status
